// File: dipc_top.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - debug fuse cleared turns the reset pin into the debug clock input
// - debug with external clock puts debug data on the oscillator output
// - debug with internal RC puts debug data on the oscillator input
// - interface-select fuse picks normal or fast two-wire debug link
// - crystal selection falls back to external clock while debugging
// - debug removes port use and, outside power-up, external reset use of the shared line
// - debug pins lose external interrupts and clock output as applicable
// - breakpoint opcode runs as two-cycle no-op with debug off
// - breakpoint is escaped opcode A5 then 00, two cycles
// - watchdog-caused break leaves the watchdog state untouched
// - programmer is SPI master, device is only SPI slave
// - programming mode entered and held only while reset is low
// - programming link is SPI mode 0, clock at most 5 MHz
// - programming logic acts on serial clock edges sampled by the system clock
// - disabled reset still resets at power-up; entry needs pin low by then
// - disabled reset case stays programming until the pin goes high
// - disabled reset case refuses a second session until power cycles
// - programming fuse on allows entry any reset, off only at power-on
// - slave select frames commands; rising edge completes the command
// - every command starts with preamble AA then 55
module dipc_top
  import dipc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // fuses and strap-like configuration
  input wire logic fuse_debug_en_n,
  input wire logic fuse_dbg_fast,
  input wire logic fuse_prog_en,
  input wire logic fuse_rst_disable,
  input wire logic [1:0] fuse_clk_sel,
  // power-on reset from the supply monitor, high while active
  input wire logic por_active,
  // shared reset/port pin
  input wire logic shared_reset_port_line,
  // core side
  input wire logic [7:0] fetch_byte,
  input wire logic fetch_valid,
  input wire logic wdt_overflow,
  output logic break_req,
  output logic brk_nop,
  output logic wdt_hold,
  output logic core_reset_n,
  output logic port_in_enable,
  // debug pin routing
  output logic debug_clock_in,
  output logic dbg_data_on_osc_out,
  output logic dbg_data_on_osc_in,
  output logic dbg_mode_fast,
  output logic [1:0] eff_clk_sel,
  output logic ext_irq_zero_en,
  output logic ext_irq_one_en,
  output logic clock_output_pin_en,
  // SPI programming pins
  input wire logic sck,
  input wire logic mosi,
  input wire logic ss_n,
  output logic miso_o,
  output logic miso_oe,
  // programming status toward the flash engine
  output logic prog_mode,
  output logic [7:0] cmd_byte,
  output logic cmd_byte_valid,
  output logic cmd_done,
  output logic cmd_reject,
  input wire logic [7:0] prog_tx_byte
);
  typedef enum logic [1:0] {
    dipc_ps_hunt0,
    dipc_ps_hunt1,
    dipc_ps_body,
    dipc_ps_bad
  } dipc_pstate_t;

  dipc_spi_if sbus ();

  // two-flop synchronisers for everything off-domain
  logic [1:0] rst_s;
  logic [1:0] sck_s;
  logic [1:0] mosi_s;
  logic [1:0] ss_s;
  logic sck_d;
  logic rst_pin;
  logic sck_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s <= 2'h3;
      sck_s <= 2'h0;
      mosi_s <= 2'h0;
      ss_s <= 2'h3;
      sck_d <= 1'b0;
    end else begin
      rst_s <= {rst_s[0], shared_reset_port_line};
      sck_s <= {sck_s[0], sck};
      mosi_s <= {mosi_s[0], mosi};
      ss_s <= {ss_s[0], ss_n};
      sck_d <= sck_s[1];
    end
  end
  assign rst_pin = rst_s[1];
  assign sck_q = sck_s[1];

  // ---------------- debug configuration ----------------
  logic dbg_on;
  logic [1:0] next_eff_clk;
  assign dbg_on = (fuse_debug_en_n == FUSE_ON);

  function automatic logic [1:0] clk_fallback(input logic [1:0] sel,
                                              input logic dbg);
    if (dbg && sel == 2'(dipc_clk_xtal)) return 2'(dipc_clk_ext);
    return sel;
  endfunction : clk_fallback

  assign next_eff_clk = clk_fallback(fuse_clk_sel, dbg_on);

  // one decode of "debug data sits on this oscillator pin", shared by
  // the data routing and by the oscillator-output pin functions that debug takes away
  function automatic logic dbg_on_src(input logic dbg,
                                      input logic [1:0] sel,
                                      input dipc_clk_t src);
    return dbg && sel == 2'(src);
  endfunction : dbg_on_src

  logic dbg_ext;
  logic dbg_rc;
  assign dbg_ext = dbg_on_src(dbg_on, next_eff_clk, dipc_clk_ext);
  assign dbg_rc = dbg_on_src(dbg_on, next_eff_clk, dipc_clk_rc);

  // ---------------- breakpoint decode ----------------
  logic esc_seen;
  logic next_esc_seen;
  logic next_break_req;
  logic next_brk_nop;
  logic next_wdt_hold;
  logic brk_hit;
  assign brk_hit = esc_seen && fetch_valid && fetch_byte == BRK_OP;

  always_comb begin
    next_esc_seen = esc_seen;
    // a second escape byte cancels the pending escape, never re-arms it
    if (fetch_valid) next_esc_seen = (fetch_byte == BRK_ESC) && !esc_seen;
    next_break_req = dbg_on && (brk_hit || wdt_overflow);
    // escape byte was the first cycle, this second byte the second
    next_brk_nop = !dbg_on && brk_hit;
    // watchdog break freezes the watchdog instead of resetting it
    next_wdt_hold = wdt_hold;
    if (dbg_on && wdt_overflow) next_wdt_hold = 1'b1;
    if (!dbg_on) next_wdt_hold = 1'b0;
  end

  // ---------------- programming entry ----------------
  // session_used is cleared only by rstn, which stands in for a power
  // cycle; a pin reset alone must not re-arm entry
  logic session_used;
  logic next_prog_mode;
  logic next_session_used;
  logic entry_ok;
  logic reset_low;
  logic pin_is_reset;
  // the pin always acts as reset during power-up, even when disabled
  // as reset by fuse or taken over as the debug clock
  assign pin_is_reset = (!dbg_on && !fuse_rst_disable) || por_active;
  assign reset_low = !rst_pin && pin_is_reset;
  // enable fuse on: any reset; off: only the power-on window
  assign entry_ok = reset_low && !prog_mode &&
                    (fuse_prog_en || por_active) &&
                    !(fuse_rst_disable && session_used);

  always_comb begin
    next_prog_mode = prog_mode;
    next_session_used = session_used;
    if (entry_ok) next_prog_mode = 1'b1;
    if (prog_mode && rst_pin) begin
      // leaving on the pin rising, also after POR when reset is disabled
      next_prog_mode = 1'b0;
      next_session_used = 1'b1;
    end
  end

  // ---------------- command framing ----------------
  dipc_pstate_t pstate;
  dipc_pstate_t next_pstate;
  logic next_cmd_valid;
  logic next_cmd_reject;
  logic [7:0] next_cmd_byte;

  always_comb begin
    next_pstate = pstate;
    next_cmd_valid = 1'b0;
    next_cmd_reject = 1'b0;
    next_cmd_byte = cmd_byte;
    if (!prog_mode) begin
      next_pstate = dipc_ps_hunt0;
    end else if (sbus.frame_end) begin
      next_pstate = dipc_ps_hunt0;
    end else if (sbus.rx_valid) begin
      unique case (pstate)
        dipc_ps_hunt0: begin
          next_pstate = (sbus.rx_byte == PRE_B0) ? dipc_ps_hunt1 : dipc_ps_bad;
        end
        dipc_ps_hunt1: begin
          next_pstate = (sbus.rx_byte == PRE_B1) ? dipc_ps_body : dipc_ps_bad;
        end
        dipc_ps_body: begin
          next_cmd_byte = sbus.rx_byte;
          next_cmd_valid = 1'b1;
        end
        // a broken preamble poisons the rest of the frame until ss rises
        dipc_ps_bad: begin
          next_pstate = dipc_ps_bad;
        end
      endcase
      next_cmd_reject = (pstate == dipc_ps_hunt0 && sbus.rx_byte != PRE_B0) ||
                        (pstate == dipc_ps_hunt1 && sbus.rx_byte != PRE_B1);
    end
  end

  // SPI edges come from the serial clock only; the system clock
  // merely samples it, so sck must stay below REF/(2*SCK_HALF_CYC)
  assign sbus.sck_rise = sck_q && !sck_d;
  assign sbus.sck_fall = !sck_q && sck_d;
  assign sbus.mosi = mosi_s[1];
  assign sbus.ss_n = ss_s[1];
  assign sbus.active = prog_mode;
  assign sbus.tx_byte = prog_tx_byte;

  dipc_spi_shift u_shift (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .bus(sbus)
  );

  // ---------------- registers ----------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      esc_seen <= 1'b0;
      break_req <= 1'b0;
      brk_nop <= 1'b0;
      wdt_hold <= 1'b0;
      prog_mode <= 1'b0;
      session_used <= 1'b0;
      pstate <= dipc_ps_hunt0;
      cmd_byte <= 8'h0000;
      cmd_byte_valid <= 1'b0;
      cmd_done <= 1'b0;
      cmd_reject <= 1'b0;
      core_reset_n <= 1'b0;
      port_in_enable <= 1'b0;
      debug_clock_in <= 1'b0;
      dbg_data_on_osc_out <= 1'b0;
      dbg_data_on_osc_in <= 1'b0;
      dbg_mode_fast <= 1'b0;
      eff_clk_sel <= 2'h0;
      ext_irq_zero_en <= 1'b0;
      ext_irq_one_en <= 1'b0;
      clock_output_pin_en <= 1'b0;
      miso_o <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      esc_seen <= next_esc_seen;
      break_req <= next_break_req;
      brk_nop <= next_brk_nop;
      wdt_hold <= next_wdt_hold;
      prog_mode <= next_prog_mode;
      session_used <= next_session_used;
      pstate <= next_pstate;
      cmd_byte <= next_cmd_byte;
      cmd_byte_valid <= next_cmd_valid;
      cmd_done <= sbus.frame_end && prog_mode;
      cmd_reject <= next_cmd_reject;
      // the core stays in reset for the whole programming session
      core_reset_n <= !(reset_low || next_prog_mode);
      // port use only when reset function is disabled and debug off
      port_in_enable <= fuse_rst_disable && !dbg_on && !por_active;
      debug_clock_in <= dbg_on && rst_pin;
      dbg_data_on_osc_out <= dbg_ext;
      dbg_data_on_osc_in <= dbg_rc;
      dbg_mode_fast <= dbg_on && fuse_dbg_fast;
      eff_clk_sel <= next_eff_clk;
      ext_irq_zero_en <= !dbg_on;
      ext_irq_one_en <= !dbg_ext;
      clock_output_pin_en <= !dbg_ext;
      // slave only: miso driven solely inside a selected frame
      // this register costs one system cycle of the sck low half
      miso_o <= sbus.miso;
      miso_oe <= prog_mode && !sbus.ss_n;
    end
  end
endmodule : dipc_top
`default_nettype wire

// File: dipc_pkg.sv
package dipc_pkg;
  // debug enable fuse polarity: a cleared fuse bit means debugging is on
  localparam logic FUSE_ON = 1'b0;
  // clock source selections
  typedef enum logic [1:0] {
    dipc_clk_ext,
    dipc_clk_rc,
    dipc_clk_xtal
  } dipc_clk_t;
  // debug link flavour
  typedef enum logic {
    dipc_dbg_normal,
    dipc_dbg_fast
  } dipc_dbg_mode_t;
  // escaped breakpoint opcode bytes
  localparam logic [7:0] BRK_ESC = 8'h00A5;
  localparam logic [7:0] BRK_OP = 8'h0000;
  localparam logic [1:0] BRK_CYCLES = 2'h2;
  // command preamble bytes
  localparam logic [7:0] PRE_B0 = 8'h00AA;
  localparam logic [7:0] PRE_B1 = 8'h0055;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  // serial clock ceiling, and the fewest system cycles per half period
  localparam int SCK_MAX_KHZ = 5000;
  localparam int REF_KHZ = 25000;
  localparam int SCK_HALF_CYC = (REF_KHZ + 2 * SCK_MAX_KHZ - 1) /
                                (2 * SCK_MAX_KHZ);
endpackage : dipc_pkg

// File: dipc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dipc_spi_if;
  logic sck_rise;
  logic sck_fall;
  logic mosi;
  logic ss_n;
  logic active;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic [7:0] tx_byte;
  logic miso;
  logic frame_end;
  modport ctl (output sck_rise, sck_fall, mosi, ss_n, active, tx_byte,
               input rx_byte, rx_valid, miso, frame_end);
  modport shf (input sck_rise, sck_fall, mosi, ss_n, active, tx_byte,
               output rx_byte, rx_valid, miso, frame_end);
endinterface : dipc_spi_if
`default_nettype wire

// File: dipc_spi_shift.sv
`timescale 1ns/1ps
`default_nettype none
module dipc_spi_shift
  import dipc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  dipc_spi_if.shf bus
);
  logic [2:0] bit_cnt;
  logic [7:0] sh_in;
  logic [7:0] sh_out;
  logic ss_prev;
  logic [2:0] next_bit_cnt;
  logic [7:0] next_sh_in;
  logic [7:0] next_sh_out;
  logic [7:0] next_rx_byte;
  logic next_rx_valid;
  logic next_frame_end;

  // mode 0: sample on rising sck, shift out on falling sck
  always_comb begin
    next_bit_cnt = bit_cnt;
    next_sh_in = sh_in;
    next_sh_out = sh_out;
    next_rx_byte = bus.rx_byte;
    next_rx_valid = 1'b0;
    next_frame_end = 1'b0;
    if (!bus.active || bus.ss_n) begin
      next_bit_cnt = 3'h0;
      next_sh_out = bus.tx_byte;
      next_frame_end = bus.active && bus.ss_n && !ss_prev;
    end else if (bus.sck_rise) begin
      next_sh_in = {sh_in[6:0], bus.mosi};
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == BYTE_LAST_BIT) begin
        next_rx_byte = {sh_in[6:0], bus.mosi};
        next_rx_valid = 1'b1;
      end
    end else if (bus.sck_fall) begin
      if (bit_cnt == 3'h0) next_sh_out = bus.tx_byte;
      else next_sh_out = {sh_out[6:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt <= 3'h0;
      sh_in <= 8'h0000;
      sh_out <= 8'h0000;
      ss_prev <= 1'b1;
      bus.rx_byte <= 8'h0000;
      bus.rx_valid <= 1'b0;
      bus.frame_end <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      sh_in <= next_sh_in;
      sh_out <= next_sh_out;
      ss_prev <= bus.ss_n;
      bus.rx_byte <= next_rx_byte;
      bus.rx_valid <= next_rx_valid;
      bus.frame_end <= next_frame_end;
    end
  end

  assign bus.miso = sh_out[7];
endmodule : dipc_spi_shift
`default_nettype wire

// File: dipc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dipc_asserts
  import dipc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk, rstn,
  // configuration and pins
  input wire logic fuse_debug_en_n, fuse_dbg_fast,
  input wire logic [1:0] fuse_clk_sel,
  input wire logic shared_reset_port_line,
  input wire logic [7:0] fetch_byte,
  input wire logic fetch_valid, wdt_overflow,
  // watched outputs
  input wire logic break_req, brk_nop, wdt_hold, port_in_enable,
  input wire logic dbg_data_on_osc_out, dbg_data_on_osc_in,
  input wire logic dbg_mode_fast, ext_irq_zero_en, ext_irq_one_en,
  input wire logic [1:0] eff_clk_sel,
  input wire logic miso_oe, prog_mode, cmd_byte_valid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [3:0] cfg_q;
  logic rst_q;
  wire [3:0] cfg = {fuse_debug_en_n, fuse_dbg_fast, fuse_clk_sel};
  // routing outputs lag the fuses by one register stage
  wire dbg_ok = rst_q && cfg == cfg_q && fuse_debug_en_n == FUSE_ON;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= 4'h0;
      rst_q <= 1'b0;
    end else begin
      cfg_q <= cfg;
      rst_q <= 1'b1;
    end
  end
  property p_osc_out;
    dbg_ok && fuse_clk_sel == 2'h0 |-> dbg_data_on_osc_out && !ext_irq_one_en;
  endproperty
  a_osc_out: assert property (p_osc_out) else $error("ext clock route");
  property p_osc_in;
    dbg_ok && fuse_clk_sel == 2'h1 |-> dbg_data_on_osc_in && !ext_irq_zero_en;
  endproperty
  a_osc_in: assert property (p_osc_in) else $error("rc route");
  property p_xtal;
    dbg_ok && fuse_clk_sel == 2'h2 |-> eff_clk_sel == 2'h0;
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal kept");
  property p_fast;
    dbg_ok |-> dbg_mode_fast == fuse_dbg_fast;
  endproperty
  a_fast: assert property (p_fast) else $error("link flavour");
  property p_port;
    dbg_ok |-> !port_in_enable;
  endproperty
  a_port: assert property (p_port) else $error("port use kept");
  property p_brk;
    fetch_valid && fetch_byte == BRK_ESC ##1
      fetch_valid && fetch_byte == BRK_OP && fuse_debug_en_n |=>
      brk_nop && !break_req;
  endproperty
  a_brk: assert property (p_brk) else $error("breakpoint nop");
  property p_wdt;
    wdt_overflow && fuse_debug_en_n == FUSE_ON && rst_q |=>
      break_req ##[0:1] wdt_hold;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog break");
  property p_hold;
    wdt_hold && fuse_debug_en_n == FUSE_ON |=> wdt_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("watchdog reset");
  property p_exit;
    shared_reset_port_line [*5] |-> !prog_mode;
  endproperty
  a_exit: assert property (p_exit) else $error("prog without reset");
  property p_quiet;
    !prog_mode && !$past(prog_mode) |-> !miso_oe && !cmd_byte_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("spi not idle");
endmodule : dipc_asserts
bind dipc_top dipc_asserts dipc_asserts_inst (.*);
`default_nettype wire

// File: dipc_prog_master.sv
`timescale 1ns/1ps
`default_nettype none
module dipc_prog_master #(
  parameter int HALF_NS = 160
) (
  // serial link toward the device
  output logic sck,
  output logic mosi,
  output logic ss_n,
  input wire logic miso_o
);
  // idle clock low and select driven high, never left floating
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  // last byte seen on the device's data output, msb first
  logic [7:0] rx_q = 8'h00;
  // msb first, data set while clock is low, sampled on the rise
  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      mosi = b[i];
      #(HALF_NS) sck = 1'b1;
      rx_q = {rx_q[6:0], miso_o};
      #(HALF_NS) sck = 1'b0;
    end
  endtask : put_byte
  task automatic frame(input logic [23:0] w);
    ss_n = 1'b0;
    #(HALF_NS);
    for (int k = 2; k >= 0; k--) begin
      put_byte(w[k*8 +: 8]);
    end
    #(2 * HALF_NS) ss_n = 1'b1;
    // released data no longer shows the last bit
    mosi = ~mosi;
    #(4 * HALF_NS);
  endtask : frame
endmodule : dipc_prog_master
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dipc_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic fuse_debug_en_n = 1'b1;
  logic fuse_dbg_fast = 1'b0;
  logic fuse_prog_en = 1'b1;
  logic fuse_rst_disable = 1'b0;
  logic [1:0] fuse_clk_sel = 2'h0;
  logic por_active = 1'b0;
  logic shared_reset_port_line = 1'b1;
  logic [7:0] fetch_byte = 8'h00;
  logic fetch_valid = 1'b0;
  logic wdt_overflow = 1'b0;
  logic [7:0] prog_tx_byte = 8'hC3;
  logic sck, mosi, ss_n, miso_o, miso_oe, break_req, brk_nop, wdt_hold;
  logic core_reset_n, port_in_enable, debug_clock_in, dbg_data_on_osc_out;
  logic dbg_data_on_osc_in, dbg_mode_fast, ext_irq_zero_en, ext_irq_one_en;
  logic clock_output_pin_en, prog_mode, cmd_byte_valid, cmd_done;
  logic cmd_reject;
  logic [1:0] eff_clk_sel;
  logic [7:0] cmd_byte, last_cmd;
  // sticky pulses: valid, done, reject, oe, break, nop
  logic [5:0] seen = 6'h00;
  logic seen_clr = 1'b0;
  logic [5:0] route_exp [3] = '{6'h20, 6'h16, 6'h20};
  wire [5:0] route = {dbg_data_on_osc_out, dbg_data_on_osc_in,
    ext_irq_zero_en, ext_irq_one_en, clock_output_pin_en, port_in_enable};
  int err_count = 0;
  int n_compared = 0;
  dipc_top dipc_top_inst (.*);
  // a released data line shows the inverse of its last value
  wire miso_line = miso_oe ? miso_o : ~miso_o;
  dipc_prog_master dipc_prog_master_inst (.sck, .mosi, .ss_n,
    .miso_o(miso_line));
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (cmd_byte_valid === 1'b1)
      last_cmd <= cmd_byte;
    seen <= (seen_clr ? 6'h00 : seen) |
      {cmd_byte_valid, cmd_done, cmd_reject, miso_oe, break_req, brk_nop};
  end
  task check(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task wait_pm(input logic v);
    for (int i = 0; i < 30 && prog_mode !== v; i++)
      tick(1);
    check("prog_mode", prog_mode, v);
    if (prog_mode !== v)
      final_report();
  endtask : wait_pm
  task fetch2(input logic [7:0] a, input logic [7:0] b);
    fetch_valid = 1'b1;
    fetch_byte = a;
    tick(1);
    fetch_byte = b;
    tick(1);
    fetch_valid = 1'b0;
    tick(3);
  endtask : fetch2
  // refusal has no completion to wait for, so the window is fixed
  task por_try(input logic v);
    shared_reset_port_line = 1'b0;
    por_active = 1'b1;
    tick(4);
    por_active = 1'b0;
    tick(12);
    check("por_entry", prog_mode, v);
  endtask : por_try
  task pwr;
    rstn = 1'b0;
    tick(2);
    rstn = 1'b1;
    tick(4);
  endtask : pwr
  task clr_seen;
    seen_clr = 1'b1;
    tick(1);
    seen_clr = 1'b0;
  endtask : clr_seen
  task wdt_kick;
    wdt_overflow = 1'b1;
    tick(1);
    wdt_overflow = 1'b0;
    tick(6);
  endtask : wdt_kick
  initial begin
    #3000000;
    err_count++;
    final_report();
  end
  initial begin
    tick(4);
    rstn = 1'b1;
    tick(4);
    fuse_debug_en_n = FUSE_ON;
    for (int s = 0; s < 3; s++) begin
      fuse_clk_sel = 2'(s);
      fuse_dbg_fast = s[0];
      tick(4);
      check("route", route, route_exp[s]);
      check("eff_clk", eff_clk_sel, (s == 1) ? 2'h1 : 2'h0);
      check("fast", dbg_mode_fast, s[0]);
    end
    check("dcl_hi", debug_clock_in, 1'b1);
    shared_reset_port_line = 1'b0;
    tick(4);
    check("dcl_lo", debug_clock_in, 1'b0);
    shared_reset_port_line = 1'b1;
    clr_seen();
    fetch2(BRK_ESC, BRK_OP);
    check("brk_dbg", seen, 6'h02);
    clr_seen();
    wdt_kick();
    check("wdt", {seen[1], wdt_hold}, 2'h3);
    // the emulator resets the target before resuming after the break
    pwr();
    check("wdt_rst", wdt_hold, 1'b0);
    wdt_kick();
    fuse_debug_en_n = ~FUSE_ON;
    tick(4);
    check("wdt_off", wdt_hold, 1'b0);
    check("dcl_off", debug_clock_in, 1'b0);
    clr_seen();
    fetch2(BRK_ESC, 8'h73);
    fetch2(BRK_ESC, BRK_OP);
    check("nop", seen, 6'h01);
    shared_reset_port_line = 1'b0;
    wait_pm(1'b1);
    check("core_rst", core_reset_n, 1'b0);
    clr_seen();
    dipc_prog_master_inst.frame({PRE_B0, PRE_B1, 8'h60});
    tick(10);
    check("cmd", last_cmd, 8'h60);
    check("frame", seen, 6'h34);
    check("miso", dipc_prog_master_inst.rx_q, prog_tx_byte);
    clr_seen();
    dipc_prog_master_inst.frame({8'h12, PRE_B1, 8'h60});
    tick(10);
    check("bad_pre", seen[5:3], 3'h3);
    shared_reset_port_line = 1'b1;
    wait_pm(1'b0);
    check("core_run", core_reset_n, 1'b1);
    clr_seen();
    dipc_prog_master_inst.frame({PRE_B0, PRE_B1, 8'h60});
    tick(10);
    check("idle", seen[5:2], 4'h0);
    fuse_prog_en = 1'b0;
    shared_reset_port_line = 1'b0;
    tick(12);
    check("no_entry", prog_mode, 1'b0);
    por_try(1'b1);
    shared_reset_port_line = 1'b1;
    wait_pm(1'b0);
    pwr();
    fuse_rst_disable = 1'b1;
    por_try(1'b1);
    shared_reset_port_line = 1'b1;
    wait_pm(1'b0);
    por_try(1'b0);
    shared_reset_port_line = 1'b1;
    pwr();
    // disabled reset: a low pin after power-up is only a port level
    fuse_prog_en = 1'b1;
    shared_reset_port_line = 1'b0;
    tick(12);
    check("pin", {prog_mode, core_reset_n, port_in_enable}, 3'h3);
    por_try(1'b1);
    final_report();
  end
endmodule : testbench
`default_nettype wire
